// ===== hdl/rx_signal_noise_qualifier.sv
// Signal and noise qualifier with dual settings and down-conversion NCO
`timescale 1ns/100ps
module rx_signal_noise_qualifier
   import sig_noise_pkg::*;
#(
   parameter int PW = 16,                    // Signal power width
   parameter int XW = 8                      // IF sample width
) (
   // Clock and reset
   input  wire logic          mclk,
   input  wire logic          rst_n,
   // Register write port
   input  wire logic          wr_en,
   input  wire logic [7:0]    wr_addr,
   input  wire logic [7:0]    wr_data,
   // Operating context
   input  wire logic          set_b_sel,     // High selects set B
   input  wire logic          wake_mode,     // High uses wake threshold
   input  wire logic [1:0]    auto_range_code,
   input  wire logic [7:0]    noise_threshold_a,
   input  wire logic [7:0]    noise_threshold_b,
   // Detector inputs
   input  wire logic          power_valid,
   input  wire logic [PW-1:0] signal_power_value,
   input  wire logic [7:0]    fm_noise_power_value,
   // IF samples
   input  wire logic [XW-1:0] if_sample,
   // Detector outputs
   output logic               sig_detect,
   output logic               noise_detect,
   output logic               data_present,
   // Status readouts
   output logic [7:0]         power_readout,
   output logic [7:0]         noise_readout,
   // Mixer outputs
   output logic [23:0]        osc_incr,
   output logic [XW-1:0]      i_mix,
   output logic [XW-1:0]      q_mix
);
   // =====================================
   // Functions
   // Normal range code to shift count
   function automatic logic [3:0] norm_shift(input logic [1:0] c);
      norm_shift = 4'h4 + {1'b0, c, 1'b0}; // R09
   endfunction
   // Low range code to shift count
   function automatic logic [3:0] low_shift(input logic [1:0] c);
      low_shift = 4'h2 + {1'b0, c, 1'b0}; // R08
   endfunction
   // Clamp a scaled power value into one status byte
   function automatic logic [7:0] sat8(input logic [PW-1:0] v);
      sat8 = (v > PW'(8'hff)) ? 8'hff : v[7:0];
   endfunction

   // =====================================
   // Settings, index 0 is set A, index 1 set B
   logic [7:0] run_reg   [2];     // Counter and run level
   logic [7:0] wake_reg  [2];     // Wake level
   logic [7:0] ndcfg_reg [2];     // Mode and noise tuning
   logic [7:0] low_reg   [2];     // Source, manual, low level
   logic [7:0] sel_reg   [2];     // Range factor codes
   logic [23:0] incr_reg [2];     // Oscillator increment

   // Address decode, one hit per register and set
   wire hit_run_a  = wr_en && wr_addr == OFS_RUN_A;
   wire hit_run_b  = wr_en && wr_addr == OFS_RUN_B;
   wire hit_wake_a = wr_en && wr_addr == OFS_WAKE_A;
   wire hit_wake_b = wr_en && wr_addr == OFS_WAKE_B;
   wire hit_mode_a = wr_en && wr_addr == OFS_NDCFG_A;
   wire hit_mode_b = wr_en && wr_addr == OFS_NDCFG_B;
   wire hit_low_a  = wr_en && wr_addr == OFS_LOW_A;
   wire hit_low_b  = wr_en && wr_addr == OFS_LOW_B;
   wire hit_sel_a  = wr_en && wr_addr == OFS_SEL_A;
   wire hit_sel_b  = wr_en && wr_addr == OFS_SEL_B;
   wire hit_n0_a   = wr_en && wr_addr == OFS_NCO0_A;
   wire hit_n1_a   = wr_en && wr_addr == OFS_NCO1_A;
   wire hit_n2_a   = wr_en && wr_addr == OFS_NCO2_A;
   wire hit_n0_b   = wr_en && wr_addr == OFS_NCO0_B;
   wire hit_n1_b   = wr_en && wr_addr == OFS_NCO1_B;
   wire hit_n2_b   = wr_en && wr_addr == OFS_NCO2_B;

   // Register file; unmapped writes fall through and are dropped.
   // Nothing is readable back here, only the status readouts.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int s = 0; s < 2; s++) begin
            run_reg[s]   <= RST_ZERO;
            wake_reg[s]  <= RST_ZERO;
            ndcfg_reg[s] <= RST_ZERO;
            low_reg[s]   <= RST_ZERO;
            sel_reg[s]   <= RST_SEL;
            incr_reg[s]  <= 24'h000000;
         end
      end else begin
         if (hit_run_a)  run_reg[0]   <= wr_data; // R04 R12 R19
         if (hit_run_b)  run_reg[1]   <= wr_data; // R04 R12 R19
         if (hit_wake_a) wake_reg[0]  <= wr_data; // R05 R12
         if (hit_wake_b) wake_reg[1]  <= wr_data; // R05 R12
         if (hit_mode_a) ndcfg_reg[0] <= wr_data; // R02 R12
         if (hit_mode_b) ndcfg_reg[1] <= wr_data; // R02 R12
         if (hit_low_a)  low_reg[0]   <= wr_data; // R18 R12
         if (hit_low_b)  low_reg[1]   <= wr_data; // R18 R12
         if (hit_sel_a)  sel_reg[0]   <= wr_data; // R08 R09 R12
         if (hit_sel_b)  sel_reg[1]   <= wr_data; // R08 R09 R12
         if (hit_n0_a)   incr_reg[0][7:0]   <= wr_data; // R13
         if (hit_n1_a)   incr_reg[0][15:8]  <= wr_data; // R13
         if (hit_n2_a)   incr_reg[0][23:16] <= wr_data; // R13
         if (hit_n0_b)   incr_reg[1][7:0]   <= wr_data; // R13
         if (hit_n1_b)   incr_reg[1][15:8]  <= wr_data; // R13
         if (hit_n2_b)   incr_reg[1][23:16] <= wr_data; // R13
      end
   end

   // =====================================
   // Active set selection
   wire        bsel     = set_b_sel;
   wire [7:0]  run_cfg  = run_reg[bsel];
   wire [7:0]  mode_cfg = ndcfg_reg[bsel];
   wire [7:0]  low_cfg  = low_reg[bsel];
   wire [7:0]  sel_cfg  = sel_reg[bsel];
   wire [7:0]  nthr     = bsel ? noise_threshold_b : noise_threshold_a;
   // Noise tuning bits 3:0 are kept for software only; the
   // detector here has a fixed comparator and ignores them.
   // Wake level replaces run level while in wake-up operation
   wire [5:0]  sig_thr  = wake_mode ? wake_reg[bsel][THR_HI:0]
                                    : run_cfg[THR_HI:0]; // R05
   wire [5:0]  low_thr  = low_cfg[THR_HI:0];                // R18
   wire [1:0]  need_cnt = run_cfg[CNT_HI:CNT_LO];           // R04
   wire        man_rng  = low_cfg[MAN_BIT];
   wire        src_low  = low_cfg[SRC_BIT];
   detect_mode_t mode;                                      // Decoded detection mode
   assign mode = detect_mode_t'(mode_cfg[MODE_HI:MODE_LO]); // R02

   // Range factors
   wire [1:0] norm_code = man_rng ? sel_cfg[NF_HI:0] : auto_range_code; // R07
   wire [3:0] nshift    = norm_shift(norm_code);                        // R09
   wire [3:0] lshift    = low_shift(sel_cfg[LOF_HI:LOF_LO]);            // R08

   // Scaled power values
   wire [PW-1:0] norm_pwr = signal_power_value >> nshift; // R10
   wire [PW-1:0] low_pwr  = signal_power_value >> lshift; // R10

   // Threshold comparisons
   wire above_sig = norm_pwr > PW'(sig_thr);            // R01 R10
   wire above_low = low_pwr > PW'(low_thr);             // R03
   wire quiet_fm  = fm_noise_power_value < nthr;        // R01

   // =====================================
   // Consecutive-hit counter for the signal detector
   logic [1:0] hit_cnt_reg;
   logic [1:0] hit_cnt_next;
   logic       sig_ok_reg;
   logic       sig_ok_next;
   logic       noise_ok_reg;
   logic       low_ok_reg;

   // Counter saturates at 3, the largest setting, so it cannot wrap
   // back to a miss in a long run of strong samples.
   assign hit_cnt_next = !above_sig ? 2'h0 :
                         (hit_cnt_reg == 2'h3) ? 2'h3 : hit_cnt_reg + 2'h1;
   // Setting 0 bypasses the counter and passes each sample straight
   assign sig_ok_next  = (need_cnt == 2'h0) ? above_sig
                                            : (hit_cnt_next >= need_cnt); // R04

   // Detector flags update once per power sample
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hit_cnt_reg  <= 2'h0;
         sig_ok_reg   <= 1'b0;
         noise_ok_reg <= 1'b0;
         low_ok_reg   <= 1'b0;
      end else if (power_valid) begin
         hit_cnt_reg  <= hit_cnt_next;
         sig_ok_reg   <= sig_ok_next; // R01
         noise_ok_reg <= quiet_fm;    // R01
         low_ok_reg   <= above_low;   // R03
      end
   end

   // =====================================
   // Mode combination
   logic present_next;
   always_comb begin
      case (mode)
         MODE_SIG:   present_next = sig_ok_reg;                   // R02
         MODE_NOISE: present_next = noise_ok_reg;                 // R02
         MODE_BOTH:  present_next = sig_ok_reg && noise_ok_reg;   // R02
         MODE_GATED: present_next = sig_ok_reg && noise_ok_reg
                                    && low_ok_reg;                // R03
         default:    present_next = 1'b0;
      endcase
   end

   // Gated noise flag is masked when below the low threshold
   wire noise_flag = (mode == MODE_GATED) ? (noise_ok_reg && low_ok_reg)
                                          : noise_ok_reg; // R03

   // Readout source: low-scaled signal during low-threshold calibration
   wire [7:0] readout_next = src_low ? sat8(low_pwr) : sat8(norm_pwr); // R06

   // Output registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sig_detect    <= 1'b0;
         noise_detect  <= 1'b0;
         data_present  <= 1'b0;
         power_readout <= 8'h00;
         noise_readout <= 8'h00;
      end else begin
         sig_detect    <= sig_ok_reg;
         noise_detect  <= noise_flag;
         data_present  <= present_next;   // R01 R02
         power_readout <= readout_next;   // R06 R19
         noise_readout <= fm_noise_power_value; // R19
      end
   end

   // =====================================
   // DDS and I/Q mixer
   // The LO is a square wave from the phase quadrant: cheap, but it
   // leaves odd harmonics for the following CIC filter to remove.
   logic [23:0] phase_reg;
   wire  [23:0] incr_act = incr_reg[bsel];
   wire         cos_neg  = phase_reg[23] ^ phase_reg[22];
   wire         sin_neg  = phase_reg[23];
   wire [XW-1:0] neg_x   = XW'(~if_sample + 1'b1);

   // Phase accumulator and mixer products
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg <= 24'h000000;
         osc_incr  <= 24'h000000;
         i_mix     <= '0;
         q_mix     <= '0;
      end else begin
         phase_reg <= phase_reg + incr_act;            // R14
         osc_incr  <= incr_act;                        // R13
         i_mix     <= cos_neg ? neg_x : if_sample;     // R14
         q_mix     <= sin_neg ? if_sample : neg_x;     // R14
      end
   end

   // =====================================
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_sig_mode;
      mode == MODE_SIG && $stable(mode) |=> data_present == $past(sig_ok_reg);
   endproperty
   a_sig_mode: assert property (p_sig_mode) else $error("signal mode mismatch"); // R02

   property p_noise_mode;
      mode == MODE_NOISE |=> data_present == $past(noise_ok_reg);
   endproperty
   a_noise_mode: assert property (p_noise_mode) else $error("noise mode mismatch"); // R02

   property p_gated;
      mode == MODE_GATED && !low_ok_reg |=> !data_present && !noise_detect;
   endproperty
   a_gated: assert property (p_gated) else $error("gate not applied"); // R03

   property p_nocnt;
      power_valid && need_cnt == 2'h0 |=> sig_ok_reg == $past(above_sig);
   endproperty
   a_nocnt: assert property (p_nocnt) else $error("counter not bypassed"); // R04

   property p_cnt3;
      power_valid && need_cnt != 2'h0 && !above_sig |=> !sig_ok_reg;
   endproperty
   a_cnt3: assert property (p_cnt3) else $error("miss kept detect"); // R04

   property p_shift_auto;
      !man_rng |-> nshift == 4'h4 + {1'b0, auto_range_code, 1'b0};
   endproperty
   a_shift_auto: assert property (p_shift_auto) else $error("auto factor wrong"); // R07

   property p_src;
      src_low
         |=> power_readout == sat8($past(signal_power_value) >> $past(lshift));
   endproperty
   a_src: assert property (p_src) else $error("readout source wrong"); // R06

   property p_nco_write;
      hit_n2_a ##1 !bsel |=> osc_incr[23:16] == $past(wr_data, 2);
   endproperty
   a_nco_write: assert property (p_nco_write) else $error("increment lost"); // R13

   property p_phase;
      $stable(incr_act) |=> phase_reg == $past(phase_reg) + $past(incr_act);
   endproperty
   a_phase: assert property (p_phase) else $error("phase step wrong"); // R14

   property p_both;
      mode == MODE_BOTH |=> data_present == $past(sig_ok_reg && noise_ok_reg);
   endproperty
   a_both: assert property (p_both) else $error("both mode mismatch"); // R02

   property p_sig_path;
      power_valid |-> ##2 sig_detect == $past(sig_ok_next, 2);
   endproperty
   a_sig_path: assert property (p_sig_path) else $error("signal flag late"); // R01

   property p_sel_write;
      hit_sel_a |=> sel_reg[0] == $past(wr_data);
   endproperty
   a_sel_write: assert property (p_sel_write) else $error("factor write lost"); // R08 R09

   property p_low_gate;
      mode == MODE_GATED |=> noise_detect == $past(noise_ok_reg && low_ok_reg);
   endproperty
   a_low_gate: assert property (p_low_gate) else $error("noise flag not gated"); // R03
endmodule

// ===== hdl/sig_noise_pkg.sv
// Constants and types shared by the signal and noise qualifier
// How it works
// R01: Compare signal and noise power against thresholds
// R02: Mode field picks signal, noise, both, gated
// R03: Gated mode: noise valid above low threshold
// R04: Run register: counter setting and six-bit level
// R05: Wake register holds separate six-bit level
// R06: Source bit steers power readout scaling
// R07: Manual bit picks register or automatic factor
// R08: Low factor codes give 2,4,6,8
// R09: Normal factor codes give 4,6,8,10
// R10: Power divided by two^factor before compare
// R11: Software writes fixed noise tuning bits
// R12: Every setting duplicated for sets A, B
// R13: Oscillator increment: 24 bits over three bytes
// R14: Increment drives DDS feeding I/Q mixer
// R15: Software computes increment from frequencies
// R16: Software derives threshold from noise statistics
// R17: Software calibrates low threshold via source bit
// R18: Low register holds six-bit low threshold
// R19: Settings write-only; status via readouts only
package sig_noise_pkg;
   // =====================================
   // Register offsets, set A and set B
   localparam logic [7:0] OFS_RUN_A   = 8'h71;
   localparam logic [7:0] OFS_WAKE_A  = 8'h72;
   localparam logic [7:0] OFS_NCO0_A  = 8'h78;
   localparam logic [7:0] OFS_NCO1_A  = 8'h79;
   localparam logic [7:0] OFS_NCO2_A  = 8'h7a;
   localparam logic [7:0] OFS_NDCFG_A = 8'h81;
   localparam logic [7:0] OFS_RUN_B   = 8'h91;
   localparam logic [7:0] OFS_WAKE_B  = 8'h92;
   localparam logic [7:0] OFS_NCO0_B  = 8'h98;
   localparam logic [7:0] OFS_NCO1_B  = 8'h99;
   localparam logic [7:0] OFS_NCO2_B  = 8'h9a;
   localparam logic [7:0] OFS_NDCFG_B = 8'ha1;
   localparam logic [7:0] OFS_LOW_A   = 8'hb6;
   localparam logic [7:0] OFS_LOW_B   = 8'hb7;
   localparam logic [7:0] OFS_SEL_A   = 8'hb8;
   localparam logic [7:0] OFS_SEL_B   = 8'hb9;
   // =====================================
   // Reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_SEL  = 8'h0a;
   // =====================================
   // Field positions
   localparam int CNT_HI   = 7;
   localparam int CNT_LO   = 6;
   localparam int THR_HI   = 5;
   localparam int MODE_HI  = 5;
   localparam int MODE_LO  = 4;
   localparam int SRC_BIT  = 7;
   localparam int MAN_BIT  = 6;
   localparam int LOF_HI   = 3;
   localparam int LOF_LO   = 2;
   localparam int NF_HI    = 1;
   // =====================================
   // Detection modes
   typedef enum logic [1:0] {
      MODE_SIG, MODE_NOISE, MODE_BOTH, MODE_GATED
   } detect_mode_t;
endpackage

// ===== sim/rx_signal_noise_qualifier_bench.sv
// Self-checking bench for the signal and noise qualifier
`timescale 1ns/100ps
module rx_signal_noise_qualifier_bench;
   import sig_noise_pkg::*;
   // ==========================================
   // Stimulus and observed signals
   logic        mclk, rst_n, wr_en, set_b_sel, wake_mode, power_valid;
   logic [7:0]  wr_addr, wr_data, noise_threshold_a, noise_threshold_b;
   logic [1:0]  auto_range_code;
   logic [15:0] signal_power_value;
   logic [7:0]  fm_noise_power_value, if_sample;
   logic        sig_detect, noise_detect, data_present;
   logic [7:0]  power_readout, noise_readout, i_mix, q_mix;
   logic [23:0] osc_incr;
   // Bench copy of the active shifts and readout source
   logic [3:0]  nsh, lsh;
   logic        src;
   int          num_errors, total_checks, cycles;
   // ==========================================
   // Clock, 10 ns period
   initial mclk = 1'b0;
   always #5 mclk = ~mclk;
   rx_signal_noise_qualifier DUT (
      .mclk(mclk), .rst_n(rst_n), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
      .set_b_sel(set_b_sel), .wake_mode(wake_mode), .auto_range_code(auto_range_code),
      .noise_threshold_a(noise_threshold_a), .noise_threshold_b(noise_threshold_b),
      .power_valid(power_valid), .signal_power_value(signal_power_value),
      .fm_noise_power_value(fm_noise_power_value), .if_sample(if_sample),
      .sig_detect(sig_detect), .noise_detect(noise_detect), .data_present(data_present),
      .power_readout(power_readout), .noise_readout(noise_readout),
      .osc_incr(osc_incr), .i_mix(i_mix), .q_mix(q_mix));
   // ==========================================
   // Helpers: inputs always move 1 ns after the rising edge
   task automatic step;
      @(posedge mclk);
      #1;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // One byte write, strobe held for exactly one edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      step;
      wr_en = 1'b1;
      wr_addr = a;
      wr_data = d;
      step;
      wr_en = 1'b0;
   endtask
   // Increment shows one edge after the write edge
   task automatic incr_is(input logic [23:0] e);
      step;
      step;
      step;
      chk(osc_incr, e, "increment");
   endtask
   // One power sample; e is {signal flag, noise flag, combined result}
   task automatic det(input logic [15:0] p, input logic [7:0] n, input logic [2:0] e);
      logic [15:0] s;
      step;
      power_valid = 1'b1;
      signal_power_value = p;
      fm_noise_power_value = n;
      step;
      power_valid = 1'b0;
      step;
      step;
      s = src ? (p >> lsh) : (p >> nsh);
      chk({21'h0, sig_detect, noise_detect, data_present}, {21'h0, e}, "flags");
      chk({16'h0, power_readout}, (s > 16'h00ff) ? 24'h0000ff : {16'h0, s[7:0]}, "readout");
      chk({16'h0, noise_readout}, {16'h0, n}, "noise readout");
   endtask
   // ==========================================
   // Single exit point with the verdict
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Hang guard, far above the roughly 190 cycles the sequence needs
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         $display("[ERR] %0t run did not finish", $time);
         wrap_up;
      end
   end
   // ==========================================
   // Main sequence
   initial begin
      rst_n = 1'b0; wr_en = 1'b0; wr_addr = 8'h00; wr_data = 8'h00;
      set_b_sel = 1'b0; wake_mode = 1'b0; power_valid = 1'b0;
      auto_range_code = 2'b00; noise_threshold_a = 8'h40; noise_threshold_b = 8'h20;
      signal_power_value = 16'h0000; fm_noise_power_value = 8'h00; if_sample = 8'h10;
      nsh = 4'd4; lsh = 4'd6; src = 1'b0;
      num_errors = 0; total_checks = 0; cycles = 0;
      repeat (12) @(posedge mclk);
      #1 rst_n = 1'b1;
      step;
      chk(osc_incr, 24'h0, "increment after reset");
      // Zero increment keeps the phase at zero: in-phase passes, quadrature negates
      chk({16'h0, i_mix}, 24'h10, "i product");
      chk({16'h0, q_mix}, 24'hf0, "q product");
      // Increment bytes land independently, low byte first
      wr(OFS_NCO0_A, 8'h56);
      wr(OFS_NCO1_A, 8'h34);
      incr_is(24'h003456);
      wr(OFS_NCO2_A, 8'h12);
      incr_is(24'h123456);
      // Set B write and an unmapped write leave set A untouched
      wr(OFS_NCO2_B, 8'h9a);
      wr(8'h7b, 8'hff);
      incr_is(24'h123456);
      set_b_sel = 1'b1;
      incr_is(24'h9a0000);
      // Set B still has zero threshold, so a small power qualifies
      det(16'h00f0, 8'h30, 3'b101);
      set_b_sel = 1'b0;
      wr(OFS_NDCFG_A, 8'h07);
      wr(OFS_RUN_A, 8'h10);
      wr(OFS_LOW_A, 8'h03);
      wr(OFS_WAKE_A, 8'h20);
      det(16'h00f0, 8'h30, 3'b010);
      // Every mode against three signal/noise situations
      for (int m = 0; m < 4; m++) begin
         wr(OFS_NDCFG_A, {2'b00, m[1:0], 4'b0111});
         det(16'h0110, 8'h10, 3'b111);
         det(16'h0110, 8'h50, {2'b10, m == 0});
         det(16'h00c0, 8'h10, {1'b0, m != 3, m == 1});
      end
      wr(OFS_NDCFG_A, 8'h07);
      // Scaled value equal to the level does not qualify
      det(16'h010f, 8'h10, 3'b010);
      det(16'h0110, 8'h10, 3'b111);
      det(16'hffff, 8'h10, 3'b111);
      // Counter setting 2 needs two qualifying samples in a row
      wr(OFS_RUN_A, 8'h90);
      det(16'h0100, 8'h10, 3'b010);
      det(16'h0110, 8'h10, 3'b010);
      det(16'h0110, 8'h10, 3'b111);
      wr(OFS_RUN_A, 8'h10);
      // Wake level replaces the run level
      wake_mode = 1'b1;
      det(16'h0110, 8'h10, 3'b010);
      det(16'h0210, 8'h10, 3'b111);
      wake_mode = 1'b0;
      // Manual range takes the normal factor from the register (code 11)
      wr(OFS_SEL_A, 8'h0b);
      wr(OFS_LOW_A, 8'h43);
      nsh = 4'd10;
      det(16'h4400, 8'h10, 3'b111);
      det(16'h4000, 8'h10, 3'b010);
      wr(OFS_LOW_A, 8'h03);
      nsh = 4'd4;
      det(16'h0110, 8'h10, 3'b111);
      // Automatic factor follows the rate-derived code (01 gives 6)
      auto_range_code = 2'b01;
      nsh = 4'd6;
      det(16'h0440, 8'h10, 3'b111);
      det(16'h0400, 8'h10, 3'b010);
      auto_range_code = 2'b00;
      nsh = 4'd4;
      // Readout follows the low factor (code 11) when the source bit is set
      wr(OFS_SEL_A, 8'h0e);
      wr(OFS_LOW_A, 8'h83);
      src = 1'b1;
      lsh = 4'd8;
      wr(OFS_NDCFG_A, 8'h37);
      det(16'h0400, 8'h10, 3'b111);
      det(16'h0300, 8'h10, 3'b100);
      // Calibration done: source bit back to 0 restores normal scaling
      wr(OFS_LOW_A, 8'h03);
      src = 1'b0;
      det(16'h0300, 8'h10, 3'b100);
      wrap_up;
   end
endmodule
